// *** include/pbcs_pkg.sv ***
// constants and types of the basic control and status register pair
package pbcs_pkg;

  // register indices, byte address is index times stride
  localparam int unsigned CTRL_IDX   = 0;
  localparam int unsigned STAT_IDX   = 1;
  localparam int unsigned REG_STRIDE = 4;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned REG_W      = 16;
  localparam int unsigned BUS_W      = 32;
  localparam int unsigned MAC_W      = 8;
  localparam int unsigned PIN_N      = 5;

  // control register fields
  localparam int unsigned C_SRST     = 15;
  localparam int unsigned C_LOOP     = 14;
  localparam int unsigned C_SPD_LO   = 13;
  localparam int unsigned C_NEG_EN   = 12;
  localparam int unsigned C_PWD      = 11;
  localparam int unsigned C_ISO      = 10;
  localparam int unsigned C_RESTART  = 9;
  localparam int unsigned C_DUPLEX   = 8;
  localparam int unsigned C_COLTEST  = 7;
  localparam int unsigned C_SPD_HI   = 6;
  localparam logic [15:0] CTRL_RST   = 16'h1140;
  localparam logic [15:0] CTRL_WMASK = 16'h7580;
  localparam logic [15:0] CTRL_FIXED = 16'h0040;

  // status register fields, fixed ability bits equal the reset value
  localparam int unsigned S_NEG_DONE = 5;
  localparam int unsigned S_RFAULT   = 4;
  localparam int unsigned S_LINK     = 2;
  localparam int unsigned S_BABBLE   = 1;
  localparam logic [15:0] STAT_RST   = 16'h7949;

  // pin input order in the synchroniser vector
  localparam int unsigned P_LINK     = 0;
  localparam int unsigned P_DONE     = 1;
  localparam int unsigned P_RFAULT   = 2;
  localparam int unsigned P_BABBLE   = 3;
  localparam int unsigned P_PWD      = 4;

  // link rate codes
  localparam logic [1:0] SPD_10      = 2'h0;
  localparam logic [1:0] SPD_100     = 2'h1;
  localparam logic [1:0] SPD_1000    = 2'h2;
  localparam logic [1:0] SPD_RSV     = 2'h3;

  // bus encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NSEQ = 2'h2;
  localparam logic       HRESP_OKAY  = 1'b0;

  // soft reset duration
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned SOFT_RST_NS  = 1000;
  localparam int unsigned SOFT_RST_CYC =
    (SOFT_RST_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [0:0] {
    PBCS_RUN  = 1'b0,
    PBCS_SRST = 1'b1
  } pbcs_state_t;

  typedef struct packed {
    logic       loopback;
    logic       isolate;
    logic       neg_enable;
    logic       full_duplex;
    logic       collision_test;
    logic [1:0] forced_speed;
  } pbcs_ctrl_t;

endpackage : pbcs_pkg

// *** hdl/pbcs_sync2.sv ***
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
module pbcs_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : pbcs_sync2

// *** hdl/pbcs_regs.sv ***
// basic control and status registers of the transceiver on ahb-lite
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
module pbcs_regs #(
  parameter int unsigned SOFT_RST_CYC = pbcs_pkg::SOFT_RST_CYC,
  parameter int unsigned MAC_W        = pbcs_pkg::MAC_W
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic                        hsel,
  input  wire logic [pbcs_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [pbcs_pkg::BUS_W-1:0]  hwdata,
  input  wire logic                        hready,
  output logic      [pbcs_pkg::BUS_W-1:0]  hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic                        link_ok_pin,
  input  wire logic                        neg_done_pin,
  input  wire logic                        remote_fault_pin,
  input  wire logic                        babble_pin,
  input  wire logic                        power_down_pin,
  input  wire logic [1:0]                  neg_speed,
  input  wire logic                        neg_duplex,
  input  wire logic [MAC_W-1:0]            mac_tx_d,
  input  wire logic                        mac_tx_en,
  input  wire logic [MAC_W-1:0]            line_rx_d,
  input  wire logic                        line_rx_dv,
  input  wire logic                        line_col,
  output logic      [MAC_W-1:0]            mac_rx_d,
  output logic                             mac_rx_dv,
  output logic                             mac_col,
  output logic                             mac_oe,
  output logic      [MAC_W-1:0]            line_tx_d,
  output logic                             line_tx_en,
  output pbcs_pkg::pbcs_ctrl_t             ctrl,
  output logic      [1:0]                  link_speed,
  output logic                             link_full_duplex,
  output logic                             speed_reserved,
  output logic                             neg_restart,
  output logic                             xcvr_rst
);

  localparam int unsigned CNT_W = $clog2(SOFT_RST_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SOFT_RST_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam logic [15:0]      CTRL_INIT =
    pbcs_pkg::CTRL_RST & pbcs_pkg::CTRL_WMASK;

  // byte address match of a register index, used for reads and writes
  function automatic logic hit(
    input logic [pbcs_pkg::ADDR_W-1:0] a,
    input int unsigned                 idx
  );
    hit = (a == pbcs_pkg::ADDR_W'(idx * pbcs_pkg::REG_STRIDE));
  endfunction : hit

  // pin synchronisers
  // every pin crosses two flops before any logic reads it
  logic [pbcs_pkg::PIN_N-1:0] pin_raw;
  logic [pbcs_pkg::PIN_N-1:0] pin_s;

  assign pin_raw[pbcs_pkg::P_LINK]   = link_ok_pin;
  assign pin_raw[pbcs_pkg::P_DONE]   = neg_done_pin;
  assign pin_raw[pbcs_pkg::P_RFAULT] = remote_fault_pin;
  assign pin_raw[pbcs_pkg::P_BABBLE] = babble_pin;
  assign pin_raw[pbcs_pkg::P_PWD]    = power_down_pin;

  pbcs_sync2 #(
    .W (pbcs_pkg::PIN_N)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .d       (pin_raw),
    .q       (pin_s)
  );

  wire link_s   = pin_s[pbcs_pkg::P_LINK];
  wire done_s   = pin_s[pbcs_pkg::P_DONE];
  wire rfault_s = pin_s[pbcs_pkg::P_RFAULT];
  wire babble_s = pin_s[pbcs_pkg::P_BABBLE];
  wire pwd_s    = pin_s[pbcs_pkg::P_PWD];

  // bus address and data phase
  // a read right after a write to the same register sees the old value:
  // the write lands in its data phase, read data load at the address
  // edge, and nothing is forwarded between the two
  logic                 wr_ctrl_r;
  logic                 wr_ctrl_nxt;
  logic                 hrdata_en;
  logic [15:0]          rd_val;

  wire addr_take = ce & hsel & hready & htrans[1];
  wire rd_take   = addr_take & ~hwrite;
  wire wr_take   = addr_take & hwrite;
  wire a_ctrl    = hit(haddr, pbcs_pkg::CTRL_IDX);
  wire a_stat    = hit(haddr, pbcs_pkg::STAT_IDX);
  wire rd_stat   = rd_take & a_stat;

  // zero wait states, a low clock enable stretches the data phase
  assign hreadyout   = ce;
  assign hresp       = pbcs_pkg::HRESP_OKAY;
  assign wr_ctrl_nxt = wr_take & a_ctrl;
  assign hrdata_en   = rd_take;

  // soft reset sequencer
  // control writes are dropped while busy so the reset value holds
  pbcs_pkg::pbcs_state_t state_r;
  pbcs_pkg::pbcs_state_t state_nxt;
  logic [CNT_W-1:0]      cnt_r;
  logic [CNT_W-1:0]      cnt_nxt;
  logic [15:0]           ctrl_r;
  logic [15:0]           ctrl_nxt;
  logic                  restart_nxt;

  wire        wr_do   = wr_ctrl_r & ce & (state_r == pbcs_pkg::PBCS_RUN);
  wire [15:0] wdata   = hwdata[pbcs_pkg::REG_W-1:0];
  wire        srst_go = wr_do & wdata[pbcs_pkg::C_SRST];

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      pbcs_pkg::PBCS_RUN: begin
        if (srst_go) begin
          state_nxt = pbcs_pkg::PBCS_SRST;
          cnt_nxt   = CNT_LOAD;
        end
      end
      pbcs_pkg::PBCS_SRST: begin
        if (cnt_r == CNT_ZERO) begin
          state_nxt = pbcs_pkg::PBCS_RUN;
        end else begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
    endcase
  end

  // only writable control bits are stored
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (state_r == pbcs_pkg::PBCS_SRST) begin
      ctrl_nxt = CTRL_INIT;
    end else if (wr_do && !srst_go) begin
      ctrl_nxt = wdata & pbcs_pkg::CTRL_WMASK;
    end
  end

  assign restart_nxt = wr_do & ~srst_go & wdata[pbcs_pkg::C_RESTART];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r   <= pbcs_pkg::PBCS_RUN;
      cnt_r     <= CNT_ZERO;
      wr_ctrl_r <= 1'b0;
      ctrl_r    <= CTRL_INIT;
    end else if (ce) begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      wr_ctrl_r <= wr_ctrl_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  // restart is a one-cycle pulse and is never stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      neg_restart <= 1'b0;
    end else if (ce) begin
      neg_restart <= restart_nxt;
    end
  end

  wire srst_busy = (state_r == pbcs_pkg::PBCS_SRST);
  assign xcvr_rst = srst_busy;

  // status bits
  localparam int unsigned FLAG_N  = 2;
  localparam int unsigned FLAG_RF = 0;
  localparam int unsigned FLAG_BB = 1;

  logic              link_lat_r;
  logic              link_lat_nxt;
  wire  [FLAG_N-1:0] flag_set;
  wire  [FLAG_N-1:0] flag_q;

  assign flag_set[FLAG_RF] = rfault_s;
  assign flag_set[FLAG_BB] = babble_s;

  // clear-on-read flags; a live event wins over the clear of a read
  for (genvar g = 0; g < FLAG_N; g++) begin : g_flag
    logic flag_r;
    wire  flag_nxt = flag_set[g] | (flag_r & ~rd_stat);

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        flag_r <= 1'b0;
      end else if (ce) begin
        flag_r <= srst_busy ? 1'b0 : flag_nxt;
      end
    end

    assign flag_q[g] = flag_r;
  end

  wire rfault_flag = flag_q[FLAG_RF];
  wire babble_flag = flag_q[FLAG_BB];

  // latched low: a read rearms the latch to the live level
  assign link_lat_nxt = link_s & (link_lat_r | rd_stat);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link_lat_r <= 1'b0;
    end else if (ce) begin
      link_lat_r <= srst_busy ? 1'b0 : link_lat_nxt;
    end
  end

  // read data
  logic [15:0] ctrl_view;
  logic [15:0] stat_view;

  // live bits are merged over the stored control value
  always_comb begin
    ctrl_view = ctrl_r | pbcs_pkg::CTRL_FIXED;
    ctrl_view[pbcs_pkg::C_SRST]    = srst_busy;
    ctrl_view[pbcs_pkg::C_PWD]     = pwd_s;
    ctrl_view[pbcs_pkg::C_RESTART] = 1'b0;
  end

  always_comb begin
    // fixed abilities: 14..11, 8, 6, 3, 0 read one
    stat_view = pbcs_pkg::STAT_RST;
    stat_view[pbcs_pkg::S_NEG_DONE] = done_s;
    stat_view[pbcs_pkg::S_RFAULT]   = rfault_flag;
    stat_view[pbcs_pkg::S_LINK]     = link_lat_r;
    stat_view[pbcs_pkg::S_BABBLE]   = babble_flag;
  end

  assign rd_val = a_ctrl ? ctrl_view :
                  a_stat ? stat_view : 16'h0000;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hrdata <= '0;
    end else if (hrdata_en) begin
      hrdata <= {16'h0000, rd_val};
    end
  end

  // control outputs
  wire neg_en   = ctrl_r[pbcs_pkg::C_NEG_EN];
  wire [1:0] fspd = {ctrl_view[pbcs_pkg::C_SPD_HI],
                     ctrl_r[pbcs_pkg::C_SPD_LO]};

  assign ctrl.loopback       = ctrl_r[pbcs_pkg::C_LOOP];
  assign ctrl.isolate        = ctrl_r[pbcs_pkg::C_ISO];
  assign ctrl.neg_enable     = neg_en;
  assign ctrl.full_duplex    = ctrl_r[pbcs_pkg::C_DUPLEX];
  assign ctrl.collision_test = ctrl_r[pbcs_pkg::C_COLTEST];
  assign ctrl.forced_speed   = fspd;

  wire       fspd_rsv  = ~neg_en & (fspd == pbcs_pkg::SPD_RSV);
  wire [1:0] speed_nxt = neg_en ? neg_speed : fspd;
  wire       dup_nxt   = neg_en ? neg_duplex
                                : ctrl_r[pbcs_pkg::C_DUPLEX];

  // a reserved forced code keeps the previous rate
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link_speed       <= pbcs_pkg::SPD_10;
      link_full_duplex <= 1'b0;
      speed_reserved   <= 1'b0;
    end else if (ce) begin
      if (!fspd_rsv) begin
        link_speed <= speed_nxt;
      end
      link_full_duplex <= dup_nxt;
      speed_reserved   <= fspd_rsv;
    end
  end

  // mac side data path
  // loopback keeps the line quiet so looped data are not also sent;
  // the collision test echoes transmit enable onto the collision output while isolate is clear
  wire loop_on = ctrl_r[pbcs_pkg::C_LOOP];
  wire iso_on  = ctrl_r[pbcs_pkg::C_ISO];
  wire ct_on   = ctrl_r[pbcs_pkg::C_COLTEST];

  wire [MAC_W-1:0] rx_d_sel  = loop_on ? mac_tx_d : line_rx_d;
  wire             rx_dv_sel = loop_on ? mac_tx_en : line_rx_dv;
  wire             col_sel   = ct_on ? mac_tx_en
                                     : (line_col & ~loop_on);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mac_rx_d   <= '0;
      mac_rx_dv  <= 1'b0;
      mac_col    <= 1'b0;
      mac_oe     <= 1'b0;
      line_tx_d  <= '0;
      line_tx_en <= 1'b0;
    end else if (ce) begin
      mac_rx_d   <= iso_on ? '0 : rx_d_sel;
      mac_rx_dv  <= rx_dv_sel & ~iso_on;
      mac_col    <= col_sel & ~iso_on;
      mac_oe     <= ~iso_on & ~srst_busy;
      line_tx_d  <= (loop_on | iso_on) ? '0 : mac_tx_d;
      line_tx_en <= mac_tx_en & ~loop_on & ~iso_on;
    end
  end

  // hsize and htrans bit 0 are ignored silently, every access is a word
  wire unused_ok = &{1'b0, hsize, htrans[0]};

endmodule : pbcs_regs

// *** tb/pbcs_regs_monitor.sv ***
// assertion checker on the register block ports
`timescale 1ns/100ps
module pbcs_regs_monitor #(
  parameter int unsigned SOFT_RST_CYC = pbcs_pkg::SOFT_RST_CYC,
  parameter int unsigned MAC_W        = pbcs_pkg::MAC_W
) (
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic [1:0]           neg_speed,
  input wire logic                 neg_duplex,
  input wire logic [MAC_W-1:0]     mac_tx_d,
  input wire logic                 mac_tx_en,
  input wire logic [MAC_W-1:0]     mac_rx_d,
  input wire logic                 mac_col,
  input wire logic                 mac_oe,
  input wire logic                 line_tx_en,
  input wire pbcs_pkg::pbcs_ctrl_t ctrl,
  input wire logic [1:0]           link_speed,
  input wire logic                 link_full_duplex,
  input wire logic                 speed_reserved,
  input wire logic                 neg_restart,
  input wire logic                 xcvr_rst
);
  logic        ok_r;
  logic [15:0] cnt_r;
  // ok_r: previous edge ran normally, so registered outputs are meaningful
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ok_r <= 1'b0;
      cnt_r <= 16'h0000;
    end else begin
      ok_r <= !xcvr_rst;
      cnt_r <= xcvr_rst ? cnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  restart_pulse_a: assert property (neg_restart |=> !neg_restart)
    else $error("restart pulse too long");
  loop_back_a: assert property (ok_r && $past(ctrl.loopback &&
    !ctrl.isolate) |-> mac_rx_d == $past(mac_tx_d) && !line_tx_en)
    else $error("loopback path wrong");
  iso_pins_a: assert property (ok_r && $past(ctrl.isolate)
    |-> !mac_oe && mac_rx_d == '0) else $error("isolate not applied");
  forced_rate_a: assert property (ok_r && $past(!ctrl.neg_enable &&
    ctrl.forced_speed != 2'h3) |-> link_speed == $past(ctrl.forced_speed)
    && link_full_duplex == $past(ctrl.full_duplex))
    else $error("forced rate or duplex wrong");
  rate_hold_a: assert property (ok_r && $past(!ctrl.neg_enable &&
    ctrl.forced_speed == 2'h3) |-> speed_reserved &&
    link_speed == $past(link_speed)) else $error("reserved rate wrong");
  neg_follow_a: assert property (ok_r && $past(ctrl.neg_enable)
    |-> link_speed == $past(neg_speed) &&
    link_full_duplex == $past(neg_duplex)) else $error("neg rate wrong");
  col_test_a: assert property (ok_r && $past(ctrl.collision_test
    && !ctrl.isolate) |-> mac_col == $past(mac_tx_en))
    else $error("collision test wrong");
  srst_len_a: assert property ($fell(xcvr_rst)
    |-> cnt_r == SOFT_RST_CYC) else $error("soft reset length");
  srst_max_a: assert property (xcvr_rst |-> cnt_r <= SOFT_RST_CYC)
    else $error("soft reset too long");
endmodule : pbcs_regs_monitor

bind pbcs_regs pbcs_regs_monitor #(.SOFT_RST_CYC(SOFT_RST_CYC),
  .MAC_W(MAC_W)) i_mon (.ref_clk, .rst, .neg_speed, .neg_duplex,
  .mac_tx_d, .mac_tx_en, .mac_rx_d, .mac_col, .mac_oe, .line_tx_en,
  .ctrl, .link_speed, .link_full_duplex, .speed_reserved, .neg_restart,
  .xcvr_rst);

// *** tb/pbcs_mgmt_host.sv ***
// management controller model issuing single ahb-lite word transfers
`timescale 1ns/100ps
module pbcs_mgmt_host (
  input  wire logic        ref_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [7:0]       haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    {hsel, haddr, hwrite, hwdata} = 42'h0;
    htrans = pbcs_pkg::HTRANS_IDLE;
    hsize = 3'h2;
  end
  // address phase held until hready, then data phase held until hready
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= pbcs_pkg::HTRANS_NSEQ;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= pbcs_pkg::HTRANS_IDLE;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : pbcs_mgmt_host

// *** tb/test_pbcs_regs.sv ***
// self-checking bench of the basic control and status registers
`timescale 1ns/100ps
module test_pbcs_regs;
  localparam int unsigned SRST = 8;
  localparam logic [7:0] A_C = 8'(pbcs_pkg::CTRL_IDX * 4);
  localparam logic [7:0] A_S = 8'(pbcs_pkg::STAT_IDX * 4);
  logic        ref_clk, rst, ce, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr, mac_tx_d, line_rx_d, mac_rx_d, line_tx_d;
  logic [1:0]  htrans, neg_speed, link_speed;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        link_ok_pin, neg_done_pin, remote_fault_pin, babble_pin;
  logic        power_down_pin, neg_duplex, mac_tx_en, line_rx_dv, line_col;
  logic        mac_rx_dv, mac_col, mac_oe, line_tx_en, link_full_duplex;
  logic        speed_reserved, neg_restart, xcvr_rst;
  pbcs_pkg::pbcs_ctrl_t ctrl;
  int          err_total, checks_done, cyc;

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  pbcs_regs #(.SOFT_RST_CYC(SRST)) i_dut (.ref_clk, .rst, .ce, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .link_ok_pin, .neg_done_pin, .remote_fault_pin,
    .babble_pin, .power_down_pin, .neg_speed, .neg_duplex, .mac_tx_d,
    .mac_tx_en, .line_rx_d, .line_rx_dv, .line_col, .mac_rx_d, .mac_rx_dv,
    .mac_col, .mac_oe, .line_tx_d, .line_tx_en, .ctrl, .link_speed,
    .link_full_duplex, .speed_reserved, .neg_restart, .xcvr_rst);
  pbcs_mgmt_host i_host (.ref_clk, .hready(hreadyout), .hrdata, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata);

  task results();
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      $display("ERROR %0t: run timed out", $time);
      results();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, {16'h0000, d}, q);
    #1;
  endtask : wr
  task rdc(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0, q);
    #1;
    chk(q, {16'h0000, e});
  endtask : rdc
  task settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  task t_defaults();
    rdc(A_C, 16'h1140);
    rdc(A_S, 16'h7949);
    rdc(8'h08, 16'h0000);
    chk({hreadyout, hresp}, 2'b10);
  endtask : t_defaults
  task t_forced();
    wr(A_C, 16'h2b3f);
    chk(neg_restart, 1);
    chk(ctrl, 7'h0b);
    rdc(A_C, 16'h2140);
    chk({speed_reserved, link_speed}, 3'h5);
    wr(A_C, 16'h0000);
    settle(2);
    chk({link_full_duplex, link_speed}, 3'h2);
    wr(A_C, 16'h0100);
    settle(2);
    chk({link_full_duplex, link_speed}, 3'h6);
    wr(A_C, 16'h1100);
    settle(2);
    chk({link_full_duplex, link_speed}, 3'h1);
  endtask : t_forced
  task t_path();
    @(posedge ref_clk);
    {mac_tx_d, mac_tx_en} <= {8'h5a, 1'b1};
    wr(A_C, 16'h5180);
    settle(2);
    chk({mac_rx_d, line_tx_en, mac_col}, {8'h5a, 2'b01});
    wr(A_C, 16'h1540);
    settle(2);
    chk({mac_oe, mac_rx_d, mac_rx_dv, mac_col}, 11'h000);
    @(posedge ref_clk);
    {line_rx_d, line_rx_dv, line_col} <= {8'h3c, 2'b11};
    wr(A_C, 16'h1140);
    settle(2);
    chk({mac_oe, mac_rx_d, mac_rx_dv, line_tx_d, line_tx_en},
        {1'b1, 8'h3c, 1'b1, 8'h5a, 1'b1});
  endtask : t_path
  task t_status();
    @(posedge ref_clk);
    {link_ok_pin, neg_done_pin, remote_fault_pin, babble_pin,
     power_down_pin} <= 5'h1f;
    repeat (3) @(posedge ref_clk);
    {remote_fault_pin, babble_pin} <= 2'b00;
    settle(4);
    rdc(A_S, 16'h797b);
    rdc(A_S, 16'h796d);
    @(posedge ref_clk);
    link_ok_pin <= 1'b0;
    repeat (3) @(posedge ref_clk);
    link_ok_pin <= 1'b1;
    settle(4);
    rdc(A_S, 16'h7969);
    rdc(A_S, 16'h796d);
    rdc(A_C, 16'h1940);
    wr(A_S, 16'h0000);
    rdc(A_S, 16'h796d);
    @(posedge ref_clk);
    power_down_pin <= 1'b0;
  endtask : t_status
  task t_hold();
    @(posedge ref_clk);
    ce <= 1'b0;
    line_rx_d <= 8'ha5;
    settle(3);
    chk({hreadyout, mac_rx_d}, {1'b0, 8'h3c});
    @(posedge ref_clk);
    ce <= 1'b1;
    settle(2);
    chk({hreadyout, mac_rx_d}, {1'b1, 8'ha5});
  endtask : t_hold
  task t_soft();
    logic [31:0] q;
    int          i;
    wr(A_C, 16'h0100);
    wr(A_C, 16'h8000);
    i_host.xfer(1'b0, A_C, 32'h0, q);
    #1;
    chk({q[15], xcvr_rst}, 2'b11);
    // a write while busy must not stick
    wr(A_C, 16'h0000);
    for (i = 0; i < 400 && xcvr_rst !== 1'b0; i++) @(posedge ref_clk);
    rdc(A_C, 16'h1140);
    rdc(A_S, 16'h7969);
  endtask : t_soft

  initial begin
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    rst = 1'b1;
    ce = 1'b1;
    neg_speed = pbcs_pkg::SPD_100;
    neg_duplex = 1'b0;
    {link_ok_pin, neg_done_pin, remote_fault_pin, babble_pin,
     power_down_pin} = 5'h00;
    {mac_tx_d, mac_tx_en, line_rx_d, line_rx_dv, line_col} = 19'h0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_defaults();
    t_forced();
    t_path();
    t_status();
    t_hold();
    t_soft();
    results();
  end
endmodule : test_pbcs_regs
